// ==== adsp_params.svh ====
// Purpose: shared numbers of the converter serial port
// Assumes: included by its bare name by the package file only
// Notes: widths, positions, counts, codes and reset values only, no logic
`ifndef ADSP_PARAMS_SVH
`define ADSP_PARAMS_SVH

// frame layout
`define ADSP_CMD_W 8
`define ADSP_WORD_W 24
`define ADSP_SEL_W 3
`define ADSP_CNT_W 5
`define ADSP_CMD_RD_POS 6
`define ADSP_SEL_LSB 3
`define ADSP_CMD_LAST 5'h07
`define ADSP_WORD_LAST 5'h17

// register selection
`define ADSP_NREG 8
`define ADSP_SEL_DATA 3'h3

// write buffer
`define ADSP_BUF_DEPTH 2
`define ADSP_BUF_CNT_W 2

// reset values
`define ADSP_RDY_N_RST 1'b1
`define ADSP_WORD_RST 24'h000000

`endif

// ==== adsp_pkg.sv ====
// Purpose: types of the converter serial port
// Assumes: adsp_params.svh gives the widths
// Notes: no logic here
`include "adsp_params.svh"

package adsp_pkg;
	typedef logic [`ADSP_WORD_W-1:0] adsp_word_t;
	typedef logic [`ADSP_SEL_W-1:0] adsp_sel_t;

	// one register write headed for the register file
	typedef struct packed {
		adsp_sel_t sel;
		adsp_word_t data;
	} adsp_wr_s;

	// link-side frame phase
	typedef enum logic [1:0] {
		ADSP_ST_CMD = 2'b00,
		ADSP_ST_WRITE = 2'b01,
		ADSP_ST_READ = 2'b10
	} adsp_state_e;
endpackage : adsp_pkg

// ==== adsp_stream_if.sv ====
// Purpose: valid/ready carrier for register writes
// Assumes: both ends on the system clock
// Notes: a word moves when valid and ready are both high
`timescale 1ns/1ps
`default_nettype none

interface adsp_stream_if;
	import adsp_pkg::*;
	logic valid;
	logic ready;
	adsp_wr_s data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : adsp_stream_if

`default_nettype wire

// ==== adsp_buf.sv ====
// Purpose: two-entry buffer in the register write path
// Assumes: one clock, asynchronous active-low reset
// Notes: flags are registered so full and empty stay honest
`timescale 1ns/1ps
`default_nettype none

module adsp_buf (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// fill and drain sides
	adsp_stream_if.snk in_if,
	adsp_stream_if.src out_if
);
	import adsp_pkg::*;

	adsp_wr_s mem_r [0:`ADSP_BUF_DEPTH-1];
	logic wptr_r;
	logic rptr_r;
	logic [`ADSP_BUF_CNT_W-1:0] cnt_r;
	logic full_r;
	logic vld_r;
	logic push;
	logic pop;

	// handshakes on both sides
	assign push = in_if.valid && !full_r;
	assign pop = vld_r && out_if.ready;
	assign in_if.ready = !full_r;
	assign out_if.valid = vld_r;
	assign out_if.data = mem_r[rptr_r];

	// storage, no reset needed for data
	always_ff @(posedge clk_sys_i) begin
		if (push) begin
			mem_r[wptr_r] <= in_if.data;
		end
	end

	// pointers and occupancy
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wptr_r <= 1'b0;
			rptr_r <= 1'b0;
			cnt_r <= 2'h0;
			full_r <= 1'b0;
			vld_r <= 1'b0;
		end else begin
			if (push) begin
				wptr_r <= ~wptr_r;
			end
			if (pop) begin
				rptr_r <= ~rptr_r;
			end
			if (push && !pop) begin
				cnt_r <= cnt_r + 2'h1;
				full_r <= (cnt_r == 2'h1);
				vld_r <= 1'b1;
			end else if (pop && !push) begin
				cnt_r <= cnt_r - 2'h1;
				full_r <= 1'b0;
				vld_r <= (cnt_r == 2'h2);
			end
		end
	end
endmodule : adsp_buf

`default_nettype wire

// ==== adsp_port.sv ====
// Purpose: serial port of a sigma-delta converter, device side
// Assumes: host drives sclk, idles it high, changes din on falling edges
// Notes: register file and conversion engine sit outside this block
`timescale 1ns/1ps
`default_nettype none

module adsp_port (
	// system clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// serial pins, sclk clocks the link side
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic din_i,
	output logic dout_o,
	output logic dout_oe_o,
	// conversion engine
	input wire logic conv_done_i,
	input wire logic upd_warn_i,
	input wire adsp_pkg::adsp_word_t conv_data_i,
	// read shadow of the control registers
	input wire logic bank_we_i,
	input wire adsp_pkg::adsp_sel_t bank_addr_i,
	input wire adsp_pkg::adsp_word_t bank_data_i,
	// register writes toward the register file
	output logic wr_valid_o,
	output adsp_pkg::adsp_sel_t wr_sel_o,
	output adsp_pkg::adsp_word_t wr_data_o,
	input wire logic wr_ready_i,
	// status
	output logic overrun_o
);
	import adsp_pkg::*;

	// true when the selection names the conversion result
	function automatic logic is_data_sel(input adsp_sel_t sel);
		is_data_sel = (sel == `ADSP_SEL_DATA);
	endfunction : is_data_sel

	// link side state
	logic link_rst;
	adsp_state_e st_r;
	logic [`ADSP_CNT_W-1:0] bit_cnt_r;
	logic [`ADSP_CMD_W-2:0] cmd_sh_r;
	adsp_sel_t sel_r;
	logic [`ADSP_WORD_W-2:0] in_sh_r;
	adsp_wr_s wr_word_r;
	logic wr_tgl_r;
	logic rd_tgl_r;
	logic rd_load_r;
	adsp_word_t out_sh_r;
	logic sh_act_r;
	logic [`ADSP_CMD_W-1:0] cmd_full;
	adsp_word_t rd_word;

	// system side state
	logic [1:0] cs_sync_r;
	logic [2:0] wr_sync_r;
	logic [2:0] rd_sync_r;
	logic wr_evt;
	logic rd_evt;
	logic rdy_n_r;
	logic oe_r;
	adsp_word_t conv_word_r;
	adsp_word_t bank_r [0:`ADSP_NREG-1];
	logic pend_r;
	adsp_wr_s pend_word_r;
	logic overrun_r;

	adsp_stream_if buf_in ();
	adsp_stream_if buf_out ();

	// a high chip select ends the frame and clears the link side except the write word and toggles
	assign link_rst = !resetn_i || cs_n_i;
	assign cmd_full = {cmd_sh_r, din_i};

	// read source: result or shadowed register, quasi-static during a frame
	assign rd_word = is_data_sel(sel_r) ? conv_word_r : bank_r[sel_r];

	// frame decode on rising sclk, where din is valid
	always_ff @(posedge sclk_i or posedge link_rst) begin
		if (link_rst) begin
			st_r <= ADSP_ST_CMD;
			bit_cnt_r <= 5'h00;
			cmd_sh_r <= 7'h00;
			sel_r <= 3'h0;
			in_sh_r <= 23'h000000;
			rd_load_r <= 1'b0;
		end else begin
			case (st_r)
				ADSP_ST_CMD: begin
					cmd_sh_r <= cmd_full[`ADSP_CMD_W-2:0];
					if (bit_cnt_r == `ADSP_CMD_LAST) begin
						bit_cnt_r <= 5'h00;
						sel_r <= cmd_full[`ADSP_SEL_LSB+:`ADSP_SEL_W];
						if (cmd_full[`ADSP_CMD_RD_POS]) begin
							st_r <= ADSP_ST_READ;
							rd_load_r <= 1'b1;
						end else begin
							st_r <= ADSP_ST_WRITE;
						end
					end else begin
						bit_cnt_r <= bit_cnt_r + 5'h01;
					end
				end
				ADSP_ST_WRITE: begin
					in_sh_r <= {in_sh_r[`ADSP_WORD_W-3:0], din_i};
					if (bit_cnt_r == `ADSP_WORD_LAST) begin
						bit_cnt_r <= 5'h00;
						st_r <= ADSP_ST_CMD;
					end else begin
						bit_cnt_r <= bit_cnt_r + 5'h01;
					end
				end
				ADSP_ST_READ: begin
					rd_load_r <= 1'b0;
					if (bit_cnt_r == `ADSP_WORD_LAST) begin
						bit_cnt_r <= 5'h00;
						st_r <= ADSP_ST_CMD;
					end else begin
						bit_cnt_r <= bit_cnt_r + 5'h01;
					end
				end
				default: begin
					st_r <= ADSP_ST_CMD;
					bit_cnt_r <= 5'h00;
				end
			endcase
		end
	end

	// completed words and finished result reads, as toggles
	// held outside the chip select reset so a word outlives the frame
	always_ff @(posedge sclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wr_word_r <= '0;
			wr_tgl_r <= 1'b0;
			rd_tgl_r <= 1'b0;
		end else if (!cs_n_i) begin
			if (st_r == ADSP_ST_WRITE && bit_cnt_r == `ADSP_WORD_LAST) begin
				wr_word_r <= '{sel: sel_r, data: {in_sh_r, din_i}};
				wr_tgl_r <= ~wr_tgl_r;
			end
			if (st_r == ADSP_ST_READ && bit_cnt_r == `ADSP_WORD_LAST
					&& is_data_sel(sel_r)) begin
				rd_tgl_r <= ~rd_tgl_r;
			end
		end
	end

	// output shifter moves on falling sclk so the host samples on rising
	always_ff @(negedge sclk_i or posedge link_rst) begin
		if (link_rst) begin
			out_sh_r <= `ADSP_WORD_RST;
			sh_act_r <= 1'b0;
		end else begin
			sh_act_r <= (st_r == ADSP_ST_READ);
			if (st_r == ADSP_ST_READ && rd_load_r) begin
				out_sh_r <= rd_word;
			end else begin
				out_sh_r <= {out_sh_r[`ADSP_WORD_W-2:0], 1'b0};
			end
		end
	end

	// pin: data while shifting, otherwise the low-active ready level
	assign dout_o = sh_act_r ? out_sh_r[`ADSP_WORD_W-1] : rdy_n_r;
	assign dout_oe_o = oe_r;

	// crossings into the system domain, first stage read only by second
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cs_sync_r <= 2'b11;
			wr_sync_r <= 3'b000;
			rd_sync_r <= 3'b000;
		end else begin
			cs_sync_r <= {cs_sync_r[0], cs_n_i};
			wr_sync_r <= {wr_sync_r[1:0], wr_tgl_r};
			rd_sync_r <= {rd_sync_r[1:0], rd_tgl_r};
		end
	end

	assign wr_evt = wr_sync_r[2] ^ wr_sync_r[1];
	assign rd_evt = rd_sync_r[2] ^ rd_sync_r[1];

	// enable lags chip select by the two sync stages plus this register; released while deselected
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			oe_r <= 1'b0;
		end else begin
			oe_r <= !cs_sync_r[1];
		end
	end

	// ready: a finished conversion wins over any clear in the same cycle
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdy_n_r <= `ADSP_RDY_N_RST;
		end else if (conv_done_i) begin
			rdy_n_r <= 1'b0;
		end else if (rd_evt || upd_warn_i) begin
			rdy_n_r <= 1'b1;
		end
	end

	// result register, updated only on a finished conversion
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			conv_word_r <= `ADSP_WORD_RST;
		end else if (conv_done_i) begin
			conv_word_r <= conv_data_i;
		end
	end

	// read shadow; loaded by the register file, never by the link
	generate
		for (genvar g = 0; g < `ADSP_NREG; g++) begin : g_bank
			always_ff @(posedge clk_sys_i or negedge resetn_i) begin
				if (!resetn_i) begin
					bank_r[g] <= `ADSP_WORD_RST;
				end else if (bank_we_i && bank_addr_i == adsp_sel_t'(g)) begin
					bank_r[g] <= bank_data_i;
				end
			end
		end
	endgenerate

	// holding stage: waits for buffer room, the word on the link is stable
	// for a whole frame so it is copied once the toggle has settled
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pend_r <= 1'b0;
			pend_word_r <= '0;
			overrun_r <= 1'b0;
		end else begin
			if (wr_evt) begin
				pend_r <= 1'b1;
				pend_word_r <= wr_word_r;
				if (pend_r && !buf_in.ready) begin
					overrun_r <= 1'b1;
				end
			end else if (pend_r && buf_in.ready) begin
				pend_r <= 1'b0;
			end
		end
	end

	assign buf_in.valid = pend_r;
	assign buf_in.data = pend_word_r;

	// two-entry buffer toward the register file
	adsp_buf u_buf (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.in_if(buf_in),
		.out_if(buf_out)
	);

	assign wr_valid_o = buf_out.valid;
	assign wr_sel_o = buf_out.data.sel;
	assign wr_data_o = buf_out.data.data;
	assign buf_out.ready = wr_ready_i;
	assign overrun_o = overrun_r;
endmodule : adsp_port

`default_nettype wire

// ==== adsp_port_assertions.sv ====
// Purpose: port checks of the serial port
// Assumes: system clock domain only
// Notes: link bit timing is judged by the bench
`timescale 1ns/1ps
`default_nettype none

module adsp_port_assertions (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// serial side
	input wire logic cs_n_i,
	input wire logic dout_o,
	input wire logic dout_oe_o,
	// conversion events
	input wire logic conv_done_i,
	input wire logic upd_warn_i,
	// write stream
	input wire logic wr_valid_o,
	input wire adsp_pkg::adsp_sel_t wr_sel_o,
	input wire adsp_pkg::adsp_word_t wr_data_o,
	input wire logic wr_ready_i,
	input wire logic overrun_o
);
	import adsp_pkg::*;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	// select levels held past the two-flop sync
	sequence s_desel; cs_n_i [*5]; endsequence
	sequence s_sel; !cs_n_i [*5]; endsequence
	sequence s_stall; wr_valid_o && !wr_ready_i; endsequence
	a_pin_released: assert property (s_desel |-> !dout_oe_o)
		else $error("pin driven while deselected");
	a_pin_driven: assert property (s_sel |-> dout_oe_o)
		else $error("pin not driven while selected");
	a_oe_lags: assert property (s_desel ##1 !cs_n_i |-> !dout_oe_o ##1 !dout_oe_o)
		else $error("enable ahead of sync");
	a_ready_set: assert property (conv_done_i && cs_n_i |=> !dout_o)
		else $error("ready not low after conversion");
	a_ready_drop: assert property (upd_warn_i && !conv_done_i && cs_n_i |=> dout_o)
		else $error("ready not high before update");
	a_word_held: assert property (s_stall |=> wr_valid_o && $stable({wr_sel_o, wr_data_o}))
		else $error("word changed while stalled");
	a_ovr_sticky: assert property (overrun_o |=> overrun_o)
		else $error("overrun flag cleared");
	a_ovr_cause: assert property ($rose(overrun_o) |-> wr_valid_o && $past(wr_valid_o))
		else $error("overrun without full buffer");
endmodule : adsp_port_assertions

bind adsp_port adsp_port_assertions i_adsp_port_assertions (.clk_sys_i, .resetn_i, .cs_n_i,
	.dout_o, .dout_oe_o, .conv_done_i, .upd_warn_i, .wr_valid_o, .wr_sel_o, .wr_data_o,
	.wr_ready_i, .overrun_o);

`default_nettype wire

// ==== adsp_host_model.sv ====
// Purpose: serial master facing the port
// Assumes: clock parks high, 48 ns bit period
// Notes: clock stands still between frames
`timescale 1ns/1ps
`default_nettype none

module adsp_host_model (
	// serial pins
	output logic sclk_o,
	output logic cs_n_o,
	output logic din_o,
	input wire logic dout_i
);
	// idle, deselected
	initial begin
		sclk_o = 1'b1;
		cs_n_o = 1'b1;
		din_o = 1'b0;
	end

	// one frame; hold keeps select low for three-wire use
	task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd, input int nb,
		input bit hold, output logic [23:0] rd);
		logic [31:0] sh;
		sh = {cmd, wd};
		rd = 24'h000000;
		cs_n_o = 1'b0;
		#200; // select must cross to the system side first
		for (int i = 0; i < nb; i++) begin
			sclk_o = 1'b0;
			din_o = sh[31-i];
			#24;
			sclk_o = 1'b1;
			if (i >= 8) rd = {rd[22:0], dout_i};
			#24;
		end
		din_o = ~din_o; // stale data must not look valid
		if (!hold) cs_n_o = 1'b1;
		#200;
	endtask : xfer
endmodule : adsp_host_model

`default_nettype wire

// ==== adsp_port_tb.sv ====
// Purpose: self-checking bench of the serial port
// Assumes: host model owns the link clock
// Notes: writes stall on purpose to force overrun
`timescale 1ns/1ps
`default_nettype none

module adsp_port_tb;
	import adsp_pkg::*;
	logic clk_sys_i = 1'b0;
	logic resetn_i = 1'b0;
	logic sclk_i;
	logic cs_n_i;
	logic din_i;
	logic dout_o;
	logic dout_oe_o;
	logic conv_done_i = 1'b0;
	logic upd_warn_i = 1'b0;
	adsp_word_t conv_data_i = 24'h000000;
	logic bank_we_i = 1'b0;
	adsp_sel_t bank_addr_i = 3'h0;
	adsp_word_t bank_data_i = 24'h000000;
	logic wr_valid_o;
	adsp_sel_t wr_sel_o;
	adsp_word_t wr_data_o;
	logic wr_ready_i = 1'b0;
	logic overrun_o;
	wire dout_pin;
	adsp_word_t rd;
	int fail_count = 0;
	int comparisons = 0;

	// pin floats when not driven
	assign dout_pin = dout_oe_o ? dout_o : 1'bz;
	always #20 clk_sys_i = ~clk_sys_i;

	adsp_port i_adsp_port (.clk_sys_i, .resetn_i, .sclk_i, .cs_n_i, .din_i, .dout_o,
		.dout_oe_o, .conv_done_i, .upd_warn_i, .conv_data_i, .bank_we_i, .bank_addr_i,
		.bank_data_i, .wr_valid_o, .wr_sel_o, .wr_data_o, .wr_ready_i, .overrun_o);
	adsp_host_model i_adsp_host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .din_o(din_i),
		.dout_i(dout_pin));

	task automatic chk(input string what, input logic [26:0] exp, input logic [26:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// one-cycle conversion or update-warning pulse
	task automatic pulse(input bit warn, input adsp_word_t d);
		@(posedge clk_sys_i);
		conv_done_i <= !warn;
		upd_warn_i <= warn;
		conv_data_i <= d;
		@(posedge clk_sys_i);
		conv_done_i <= 1'b0;
		upd_warn_i <= 1'b0;
		@(posedge clk_sys_i);
		#1;
	endtask : pulse

	task automatic t_ready;
		pulse(0, 24'ha5c3f1);
		chk("ready", 27'h0, dout_o);
		chk("pin", 1'bz, dout_pin);
		i_adsp_host.xfer(8'h58, 24'h000000, 32, 0, rd);
		chk("conv read", 27'ha5c3f1, rd);
		chk("read clear", 27'h1, dout_o);
		pulse(0, 24'h123456);
		pulse(1, 24'h000000);
		chk("unread", 27'h1, dout_o);
	endtask : t_ready

	// every selection but data reads its shadow word
	task automatic t_bank;
		for (int s = 0; s < 8; s++) begin
			if (s == 3) continue;
			@(posedge clk_sys_i);
			bank_we_i <= 1'b1;
			bank_addr_i <= s[2:0];
			bank_data_i <= {s[7:0], 16'hc35a};
			@(posedge clk_sys_i);
			bank_we_i <= 1'b0;
			#1; // select falls off the system edge, no race with its sync
			i_adsp_host.xfer({2'h1, s[2:0], 3'h0}, 24'h000000, 32, 0, rd);
			chk("bank read", {s[7:0], 16'hc35a}, rd);
		end
	endtask : t_bank

	// abort, then four writes into a stalled sink
	task automatic t_write;
		adsp_word_t w [4];
		w = '{24'h111111, 24'h2d2d2d, 24'h3c3c3c, 24'h4b4b4b};
		i_adsp_host.xfer(8'h10, 24'h0f0f0f, 16, 0, rd);
		chk("aborted", 27'h0, wr_valid_o);
		for (int i = 0; i < 4; i++)
			i_adsp_host.xfer({2'h0, i[1:0], 1'h1, 3'h0}, w[i], 32, i < 3, rd);
		chk("overrun", 27'h1, overrun_o);
		for (int k = 0; k < 4; k++) begin
			if (k == 2) continue;
			for (int n = 0; n < 20 && wr_valid_o !== 1'b1; n++) @(posedge clk_sys_i);
			#1;
			chk("word", {k[1:0], 1'h1, w[k]}, {wr_sel_o, wr_data_o});
			@(posedge clk_sys_i);
			wr_ready_i <= 1'b1;
			@(posedge clk_sys_i);
			wr_ready_i <= 1'b0;
			#1;
		end
		repeat (4) @(posedge clk_sys_i);
		#1;
		chk("drained", 27'h0, wr_valid_o);
	endtask : t_write

	task automatic give_verdict;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict

	initial begin
		repeat (10) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		t_ready();
		t_bank();
		t_write();
		give_verdict();
	end

	// about thirteen frames should take far less than this
	initial begin
		#200000;
		fail_count++;
		give_verdict();
	end
endmodule : adsp_port_tb

`default_nettype wire
